// ### pkg/adcs_map.vh
// Field positions, command codes, reset values and cycle counts of the ADC control block
`ifndef ADCS_MAP_VH
`define ADCS_MAP_VH

`define ADCS_CFG_W        12
`define ADCS_CFG_RST      12'h000
`define ADCS_B_REF        11
`define ADCS_B_FMT        10
`define ADCS_B_SPER       9
`define ADCS_B_CDIV       8
`define ADCS_B_PDIF       7
`define ADCS_B_MODE_HI    6
`define ADCS_B_MODE_LO    5
`define ADCS_B_SEQ_HI     4
`define ADCS_B_SEQ_LO     3
`define ADCS_B_PINF       2
`define ADCS_B_TRG_HI     1
`define ADCS_B_TRG_LO     0

`define ADCS_CMD_CH_MAX   4'h7
`define ADCS_CMD_PDN      4'h8
`define ADCS_CMD_RDCFG    4'h9
`define ADCS_CMD_WRCFG    4'hA
`define ADCS_CMD_TST_LO   4'hB
`define ADCS_CMD_TST_HI   4'hD
`define ADCS_CMD_FRD      4'hE
`define ADCS_CMD_NOP      4'hF
`define ADCS_TST_OFS      4'h3

`define ADCS_MODE_ONE     2'h0
`define ADCS_MODE_REP     2'h1
`define ADCS_MODE_SWP     2'h2
`define ADCS_MODE_RSWP    2'h3

`define ADCS_THR_0        4'h7
`define ADCS_THR_1        4'h5
`define ADCS_THR_2        4'h3
`define ADCS_THR_3        4'h1

`define ADCS_SAMP_SHORT   6'h0C
`define ADCS_SAMP_LONG    6'h18
`define ADCS_CMD_LAST     5'h03
`define ADCS_WORD_LAST    5'h0F
`define ADCS_WORD_BITS    5'h10
`define ADCS_CONV_CLKS    6'h0C
`define ADCS_TWOS_FLIP    12'h800
`define ADCS_FIFO_DEPTH   8

`endif

// ### logic/adcs_fifo.v
// Result FIFO of the ADC control block: push, pop, clear, fill count
module adcs_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             i_core_clk,
  input  wire             i_rstn,
  input  wire             i_clear,
  input  wire             i_push,
  input  wire [WIDTH-1:0] i_wdata,
  input  wire             i_pop,
  output wire [WIDTH-1:0] o_rdata,
  output wire [3:0]       o_count,
  output wire             o_empty,
  output wire             o_full
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_r;
  reg [AW-1:0]    rd_r;
  reg [3:0]       cnt_r;
  wire            do_push;
  wire            do_pop;

  assign o_empty = (cnt_r == 4'h0);
  assign o_full  = (cnt_r == DEPTH[3:0]);
  assign o_count = cnt_r;
  assign o_rdata = mem[rd_r];
  // A push into a full FIFO is dropped; the older samples are kept
  assign do_push = i_push & ~o_full;
  assign do_pop  = i_pop & ~o_empty;

  always @(posedge i_core_clk)
  begin
    if (do_push & ~i_clear)
    begin
      mem[wr_r] <= i_wdata;
    end
  end

  always @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= 4'h0;
    end
    else if (i_clear)
    begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= 4'h0;
    end
    else
    begin
      if (do_push)
      begin
        wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
      end
      if (do_pop)
      begin
        rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + {3'h0, do_push} - {3'h0, do_pop};
    end
  end

endmodule

// ### logic/adcs_sequencer.v
// Serial command port, configuration word and conversion sequencer of the ADC control block
`include "adcs_map.vh"

// Summary of operation
// - One 12-bit config word, writable and readable
// - Config word kept through power-down
// - 16-bit write survives a clock pause
// - Read-config command returns the config word
// - Bit 10 picks binary or two's complement
// - Bit 9 picks 12 or 24 sampling clocks
// - Bit 8 halves the conversion clock
// - Bit 7 selects pseudo-differential input
// - Bits 6:5 select the conversion mode
// - Bits 4:3 pick sweep order, sweep only
// - Bit 2 makes pin interrupt or done flag, mode 00 only
// - Bits 1:0 set threshold 7, 5, 3, 1
// - Sampling starts after a conversion command nibble
// - Start pin falling samples, rising converts
// - Held result shown on next read frame
// - Start pin, chip select or frame sync trigger
// - Mode 00 bypasses FIFO, flags done
// - Repeat mode discards unread FIFO, restarts
// - Sweep converts in order, stops at threshold
// - Sweep needs FIFO read before next sweep
// - Top nibble decodes the command set
// - Capture and launch edges follow framing
module adcs_sequencer #(
  parameter [5:0] CONV_CLKS = `ADCS_CONV_CLKS
) (
  input  wire        i_core_clk,
  input  wire        i_rstn,
  input  wire        i_sclk,
  input  wire        i_cs_n,
  input  wire        i_frame_sync,
  input  wire        i_sdi,
  input  wire        i_sample_start_n,
  input  wire [11:0] i_adc_result,
  output wire        o_sdo,
  output wire        o_sdo_oe,
  output wire        o_int_eoc_pin,
  output wire        o_sampling,
  output wire        o_converting,
  output wire [3:0]  o_channel_sel,
  output wire        o_pseudo_diff,
  output wire        o_ref_internal,
  output wire        o_power_down
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SAMP = 2'h1;
  localparam [1:0] ST_SEXT = 2'h2;
  localparam [1:0] ST_CONV = 2'h3;

  reg        sclk_q1_r, sclk_q2_r, cs_q1_r, cs_q2_r;
  reg        fs_q1_r, fs_q2_r, ss_q1_r, ss_q2_r, sdi_q1_r;
  reg        spi_r;
  reg        in_frame_r;
  reg [4:0]  bitcnt_r;
  reg [15:0] shift_r;
  reg [3:0]  cmd_r;
  reg [15:0] osh_r;
  reg        sdo_r;
  reg        sdo_oe_r;
  reg [11:0] cfg_r;
  reg [1:0]  state_r;
  reg [5:0]  cnt_r;
  reg        div_r;
  reg [3:0]  chan_r;
  reg [2:0]  pos_r;
  reg        swp_hold_r;
  reg        rd_phase_r;
  reg        int_r;
  reg        pin_r;
  reg        pd_r;
  reg [11:0] outbuf_r;
  reg        push_r;
  reg        pop_r;
  reg        clr_r;
  reg [11:0] wdata_r;

  wire [11:0] fifo_head;
  wire [3:0]  fifo_cnt;
  wire        fifo_empty;

  wire [1:0] mode     = cfg_r[`ADCS_B_MODE_HI:`ADCS_B_MODE_LO];
  wire [1:0] seq_sel  = cfg_r[`ADCS_B_SEQ_HI:`ADCS_B_SEQ_LO];
  wire [1:0] trg_sel  = cfg_r[`ADCS_B_TRG_HI:`ADCS_B_TRG_LO];
  wire       fifo_use = (mode != `ADCS_MODE_ONE);
  wire       is_sweep = mode[1];

  wire sclk_rise = sclk_q1_r & ~sclk_q2_r;
  wire sclk_fall = ~sclk_q1_r & sclk_q2_r;
  wire cs_fall   = ~cs_q1_r & cs_q2_r;
  wire fs_fall   = ~fs_q1_r & fs_q2_r & ~cs_q1_r;
  wire ss_fall   = ~ss_q1_r & ss_q2_r;
  wire ss_rise   = ss_q1_r & ~ss_q2_r;

  // Frame sync idle high at select means plain SPI framing
  wire frame_start = (cs_fall & fs_q1_r) | fs_fall;
  wire cap_edge    = in_frame_r & (spi_r ? sclk_rise : sclk_fall) & (bitcnt_r != `ADCS_WORD_BITS);
  wire out_edge    = in_frame_r & (spi_r ? sclk_fall : sclk_rise);
  wire dec4        = cap_edge & (bitcnt_r == `ADCS_CMD_LAST);
  wire [3:0] cmd_now = {shift_r[2:0], sdi_q1_r};
  wire cmd_chan    = (cmd_now <= `ADCS_CMD_CH_MAX);
  wire cmd_test    = (cmd_now >= `ADCS_CMD_TST_LO) & (cmd_now <= `ADCS_CMD_TST_HI);
  wire cmd_conv    = cmd_chan | cmd_test;
  wire [3:0] ch_cmd = cmd_chan ? {1'b0, cmd_now[2:0]} : cmd_now - `ADCS_TST_OFS;

  wire [5:0] samp_len = cfg_r[`ADCS_B_SPER] ? `ADCS_SAMP_LONG : `ADCS_SAMP_SHORT;
  wire conv_tick = sclk_rise & (~cfg_r[`ADCS_B_CDIV] | div_r);

  reg [3:0] thr;
  always @*
  begin
    case (trg_sel)
      2'h0:    thr = `ADCS_THR_0;
      2'h1:    thr = `ADCS_THR_1;
      2'h2:    thr = `ADCS_THR_2;
      default: thr = `ADCS_THR_3;
    endcase
  end

  reg [2:0] seq_ch;
  always @*
  begin
    case (seq_sel)
      2'h0:    seq_ch = pos_r;
      2'h1:    seq_ch = {pos_r[1:0], 1'b0};
      2'h2:    seq_ch = {pos_r[2:1], 1'b0};
      default: seq_ch = {pos_r[0], 1'b0};
    endcase
  end

  // Sweep order replaces the channel of a select command; test selects stay explicit
  wire [3:0] start_ch = (is_sweep & cmd_chan) ? {1'b0, seq_ch} : ch_cmd;
  wire [11:0] result  = i_adc_result ^ (cfg_r[`ADCS_B_FMT] ? `ADCS_TWOS_FLIP : 12'h000);
  wire trig_ok = (state_r == ST_IDLE) & ~(mode == `ADCS_MODE_SWP & swp_hold_r);
  wire start_norm = dec4 & cmd_conv & ss_q1_r & trig_ok;
  wire start_ext  = ss_fall & trig_ok;
  wire conv_done  = (state_r == ST_CONV) & conv_tick & (cnt_r == CONV_CLKS - 1'b1);
  wire thr_hit    = fifo_use & conv_done & ((fifo_cnt + 4'h1) == thr);
  wire busy_nxt   = (state_r != ST_IDLE) & ~conv_done;

  always @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sclk_q1_r <= 1'b0;
      sclk_q2_r <= 1'b0;
      cs_q1_r   <= 1'b1;
      cs_q2_r   <= 1'b1;
      fs_q1_r   <= 1'b1;
      fs_q2_r   <= 1'b1;
      ss_q1_r   <= 1'b1;
      ss_q2_r   <= 1'b1;
      sdi_q1_r  <= 1'b0;
    end
    else
    begin
      sclk_q1_r <= i_sclk;
      sclk_q2_r <= sclk_q1_r;
      cs_q1_r   <= i_cs_n;
      cs_q2_r   <= cs_q1_r;
      fs_q1_r   <= i_frame_sync;
      fs_q2_r   <= fs_q1_r;
      ss_q1_r   <= i_sample_start_n;
      ss_q2_r   <= ss_q1_r;
      sdi_q1_r  <= i_sdi;
    end
  end

  // Serial port: bit count only moves on capture edges, so a stalled clock
  // between the two bytes of a write simply resumes later
  always @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      spi_r      <= 1'b1;
      in_frame_r <= 1'b0;
      bitcnt_r   <= 5'h00;
      shift_r    <= 16'h0000;
      cmd_r      <= `ADCS_CMD_NOP;
      osh_r      <= 16'h0000;
      sdo_r      <= 1'b0;
      sdo_oe_r   <= 1'b0;
      cfg_r      <= `ADCS_CFG_RST;
      pd_r       <= 1'b0;
    end
    else
    begin
      if (cs_fall)
      begin
        spi_r <= fs_q1_r;
      end
      if (cs_q1_r)
      begin
        in_frame_r <= 1'b0;
        sdo_oe_r   <= 1'b0;
      end
      else if (frame_start)
      begin
        in_frame_r <= 1'b1;
        sdo_oe_r   <= 1'b1;
        bitcnt_r   <= 5'h00;
        cmd_r      <= `ADCS_CMD_NOP;
        // A waiting FIFO head goes out before the command is even known
        if (rd_phase_r & ~fifo_empty)
        begin
          osh_r <= {fifo_head, 4'h0};
          sdo_r <= fifo_head[11];
        end
        else
        begin
          osh_r <= {outbuf_r, 4'h0};
          sdo_r <= outbuf_r[11];
        end
      end
      else
      begin
        if (cap_edge)
        begin
          shift_r  <= {shift_r[14:0], sdi_q1_r};
          bitcnt_r <= bitcnt_r + 5'h01;
        end
        if (dec4)
        begin
          cmd_r <= cmd_now;
          pd_r  <= (cmd_now == `ADCS_CMD_PDN);
        end
        if (dec4 & (cmd_now == `ADCS_CMD_RDCFG))
        begin
          osh_r <= {1'b0, cfg_r, 3'h0};
        end
        else if (out_edge)
        begin
          osh_r <= {osh_r[14:0], 1'b0};
          sdo_r <= osh_r[14];
        end
        if (cap_edge & (bitcnt_r == `ADCS_WORD_LAST) & (cmd_r == `ADCS_CMD_WRCFG))
        begin
          cfg_r <= {shift_r[10:0], sdi_q1_r};
        end
      end
    end
  end

  // Conversion sequencer
  always @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_r    <= ST_IDLE;
      cnt_r      <= 6'h00;
      div_r      <= 1'b0;
      chan_r     <= 4'h0;
      pos_r      <= 3'h0;
      swp_hold_r <= 1'b0;
      rd_phase_r <= 1'b0;
      int_r      <= 1'b0;
      outbuf_r   <= 12'h000;
      push_r     <= 1'b0;
      pop_r      <= 1'b0;
      clr_r      <= 1'b0;
      wdata_r    <= 12'h000;
      pin_r      <= 1'b1;
    end
    else
    begin
      push_r <= 1'b0;
      pop_r  <= 1'b0;
      clr_r  <= 1'b0;
      if (frame_start)
      begin
        int_r <= 1'b0;
      end
      if (dec4 & cmd_chan & ~is_sweep)
      begin
        chan_r <= ch_cmd;
      end
      case (state_r)
        ST_IDLE:
        begin
          if (start_norm | start_ext)
          begin
            state_r <= start_norm ? ST_SAMP : ST_SEXT;
            cnt_r   <= 6'h00;
            div_r   <= 1'b0;
            if (start_norm)
            begin
              chan_r <= start_ch;
            end
            else if (is_sweep)
            begin
              chan_r <= {1'b0, seq_ch};
            end
            if (is_sweep)
            begin
              pos_r <= pos_r + 3'h1;
            end
            // Unread data from the last run is dropped before new samples land
            if (rd_phase_r & (mode != `ADCS_MODE_SWP))
            begin
              clr_r      <= 1'b1;
              rd_phase_r <= 1'b0;
            end
          end
        end
        ST_SAMP:
        begin
          if (sclk_rise)
          begin
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == samp_len - 6'h01)
            begin
              state_r <= ST_CONV;
              cnt_r   <= 6'h00;
            end
          end
        end
        ST_SEXT:
        begin
          if (ss_rise)
          begin
            state_r <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          if (sclk_rise)
          begin
            div_r <= ~div_r;
          end
          if (conv_tick)
          begin
            cnt_r <= cnt_r + 6'h01;
          end
          if (conv_done)
          begin
            state_r  <= ST_IDLE;
            outbuf_r <= result;
            if (fifo_use)
            begin
              push_r  <= 1'b1;
              wdata_r <= result;
            end
            else
            begin
              int_r <= ~cfg_r[`ADCS_B_PINF];
            end
            if (thr_hit)
            begin
              int_r      <= 1'b1;
              rd_phase_r <= 1'b1;
              if (mode == `ADCS_MODE_SWP)
              begin
                swp_hold_r <= 1'b1;
              end
            end
            if ((mode == `ADCS_MODE_SWP) & (pos_r == 3'h0))
            begin
              swp_hold_r <= 1'b1;
            end
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
      if (dec4 & rd_phase_r)
      begin
        if (cmd_now == `ADCS_CMD_FRD)
        begin
          pop_r <= 1'b1;
          if (fifo_cnt == 4'h1)
          begin
            rd_phase_r <= 1'b0;
          end
        end
        else if ((cmd_now != `ADCS_CMD_NOP) & (mode != `ADCS_MODE_SWP))
        begin
          clr_r      <= 1'b1;
          rd_phase_r <= 1'b0;
        end
      end
      if (swp_hold_r & fifo_empty & ~rd_phase_r & ~push_r)
      begin
        swp_hold_r <= 1'b0;
        pos_r      <= 3'h0;
      end
      if (!is_sweep)
      begin
        pos_r <= 3'h0;
      end
      // The done flag only exists in mode 00; other modes always interrupt
      if (cfg_r[`ADCS_B_PINF] & ~fifo_use)
      begin
        pin_r <= ~busy_nxt;
      end
      else
      begin
        // A threshold hit in the cycle of a frame start still pulls the pin low
        pin_r <= ~((int_r & ~frame_start) | thr_hit);
      end
    end
  end

  adcs_fifo #(
    .WIDTH (`ADCS_CFG_W),
    .DEPTH (`ADCS_FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_clear    (clr_r),
    .i_push     (push_r),
    .i_wdata    (wdata_r),
    .i_pop      (pop_r),
    .o_rdata    (fifo_head),
    .o_count    (fifo_cnt),
    .o_empty    (fifo_empty),
    .o_full     ()
  );

  reg sampling_r, converting_r;
  reg [3:0] chsel_r;
  reg pdif_r, refi_r, pdo_r;
  always @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sampling_r   <= 1'b0;
      converting_r <= 1'b0;
      chsel_r      <= 4'h0;
      pdif_r       <= 1'b0;
      refi_r       <= 1'b0;
      pdo_r        <= 1'b0;
    end
    else
    begin
      sampling_r   <= (state_r == ST_SAMP) | (state_r == ST_SEXT);
      converting_r <= (state_r == ST_CONV);
      chsel_r      <= chan_r;
      pdif_r       <= cfg_r[`ADCS_B_PDIF];
      refi_r       <= cfg_r[`ADCS_B_REF];
      pdo_r        <= pd_r;
    end
  end

  assign o_sdo          = sdo_r;
  assign o_sdo_oe       = sdo_oe_r;
  assign o_int_eoc_pin  = pin_r;
  assign o_sampling     = sampling_r;
  assign o_converting   = converting_r;
  assign o_channel_sel  = chsel_r;
  assign o_pseudo_diff  = pdif_r;
  assign o_ref_internal = refi_r;
  assign o_power_down   = pdo_r;

endmodule

// ### testbench/adcs_host_model.sv
// Host serial port model: SPI or DSP framing, counted runs of free clocks and the start pin
module adcs_host_model (
  input  wire  i_core_clk,
  input  wire  i_sdo,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_fs,
  output logic o_sdi,
  output logic o_start_n
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_fs = 1'b1;
    o_sdi = 1'b0;
    o_start_n = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  task automatic pin(input logic v);
    wt(1);
    o_start_n <= v;
  endtask

  // Each sclk phase lasts 4 core cycles, twice what the port's synchroniser needs
  task automatic xfer(input bit dsp, input bit pause, input logic [15:0] w, output logic [15:0] r);
    wt(1);
    o_sclk <= dsp;
    o_fs <= !dsp;
    wt(2);
    o_cs_n <= 1'b0;
    wt(4);
    if (dsp)
    begin
      o_fs <= 1'b1;
      wt(4);
      o_fs <= 1'b0;
      wt(4);
    end
    for (int i = 15; i >= 0; i--)
    begin
      o_sdi <= w[i];
      wt(4);
      r[i] = i_sdo;
      o_sclk <= !dsp;
      wt(4);
      o_sclk <= dsp;
      if (pause && i == 8)
        wt(40);
    end
    wt(4);
    o_cs_n <= 1'b1;
    o_fs <= 1'b1;
    // Released data line must not keep looking valid
    o_sdi <= ~o_sdi;
    wt(4);
  endtask

  // Conversion ticks need sclk outside frames; it stands still otherwise
  task automatic clocks(input int n);
    repeat (n)
    begin
      o_sclk <= 1'b0;
      wt(4);
      o_sclk <= 1'b1;
      wt(4);
    end
    o_sclk <= 1'b0;
  endtask
endmodule

// ### testbench/adcs_sequencer_sva.sv
// Port checker for the ADC serial control and sequencer
module adcs_sequencer_sva (
  input wire       i_core_clk,
  input wire       i_rstn,
  input wire       i_cs_n,
  input wire       i_sample_start_n,
  input wire       o_sdo_oe,
  input wire       o_int_eoc_pin,
  input wire       o_sampling,
  input wire       o_converting,
  input wire [3:0] o_channel_sel,
  input wire       o_pseudo_diff,
  input wire       o_ref_internal,
  input wire       o_power_down
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  oe_idle_a: assert property (i_cs_n [*4] |=> !o_sdo_oe)
    else $error("Output enabled outside a frame");
  oe_start_a: assert property ($rose(o_sdo_oe) |-> !$past(i_cs_n, 2))
    else $error("Output enabled without chip select");
  busy_excl_a: assert property (!(o_sampling && o_converting))
    else $error("Sampling and converting together");
  conv_follow_a: assert property ($fell(o_sampling) && !o_power_down |-> ##[0:2] o_converting)
    else $error("Sampling ended without conversion");
  ext_start_a: assert property ($fell(i_sample_start_n) && i_cs_n && !o_sampling && !o_converting
    && !o_power_down |-> ##[1:4] o_sampling)
    else $error("Start pin fall did not start sampling");
  ext_conv_a: assert property ($rose(i_sample_start_n) && o_sampling |-> ##[1:4] (o_converting && !o_sampling))
    else $error("Start pin rise did not start conversion");
  pin_cause_a: assert property ($fell(o_int_eoc_pin) |-> o_sampling || o_converting || $past(o_converting)
    || $past(o_converting, 2) || $past(o_converting, 3))
    else $error("Shared pin fell without conversion activity");
  chan_range_a: assert property (o_channel_sel <= 4'hA)
    else $error("Channel select out of range");
  cfg_hold_a: assert property (i_cs_n [*4] |=> $stable(o_pseudo_diff) && $stable(o_ref_internal))
    else $error("Configuration changed outside a frame");

  cover property ($rose(o_converting));
  cover property ($fell(o_int_eoc_pin));
  cover property ($fell(i_sample_start_n) ##[1:4] o_sampling);
endmodule

bind adcs_sequencer adcs_sequencer_sva chk_i (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_cs_n(i_cs_n), .i_sample_start_n(i_sample_start_n),
  .o_sdo_oe(o_sdo_oe), .o_int_eoc_pin(o_int_eoc_pin), .o_sampling(o_sampling), .o_converting(o_converting),
  .o_channel_sel(o_channel_sel), .o_pseudo_diff(o_pseudo_diff), .o_ref_internal(o_ref_internal),
  .o_power_down(o_power_down));

// ### testbench/testbench.sv
// Self-checking bench for the ADC serial control and sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // Short conversion keeps each run of free clocks brief
  localparam [5:0] CONV = 6'h04;
  logic        i_core_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic [11:0] i_adc_result;
  wire         sclk, cs_n, fs, sdi, start_n, sdo, sdo_oe, pin, samp, conv, pdif, refi, pdn;
  wire  [3:0]  chan;
  int          num_errors = 0;
  int          check_count = 0;
  int          n_samp = 0;
  int          n_conv = 0;
  int          samp0 = 0;
  int          conv0 = 0;
  logic        sclk_d = 1'b0;
  logic [15:0] r;
  logic [11:0] c;
  logic [11:0] cfg_tab [5] = '{12'h000, 12'h400, 12'h200, 12'h100, 12'h004};

  always #50 i_core_clk = ~i_core_clk;

  adcs_sequencer #(.CONV_CLKS(CONV)) uut (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_sclk(sclk), .i_cs_n(cs_n), .i_frame_sync(fs),
    .i_sdi(sdi), .i_sample_start_n(start_n), .i_adc_result(i_adc_result), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
    .o_int_eoc_pin(pin), .o_sampling(samp), .o_converting(conv), .o_channel_sel(chan),
    .o_pseudo_diff(pdif), .o_ref_internal(refi), .o_power_down(pdn));

  adcs_host_model host (
    .i_core_clk(i_core_clk), .i_sdo(sdo), .o_sclk(sclk), .o_cs_n(cs_n), .o_fs(fs), .o_sdi(sdi),
    .o_start_n(start_n));

  // Rises are counted one cycle late, before the design can react to them
  always @(posedge i_core_clk)
  begin
    sclk_d <= sclk;
    if (sclk && !sclk_d)
    begin
      n_samp <= n_samp + int'(samp);
      n_conv <= n_conv + int'(conv);
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] w);
    host.xfer(0, 0, {4'hA, w}, r);
  endtask

  task automatic rdcfg(input logic [11:0] exp, input bit dsp);
    host.xfer(dsp, 0, 16'h9000, r);
    chk({4'h0, r[11:0]}, {4'h0, exp});
  endtask

  task automatic finish_test;
    $display("Checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #3_000_000;
    num_errors++;
    finish_test();
  end

  initial
  begin
    repeat (4) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    wr(12'h000);
    rdcfg(12'h000, 0);
    host.xfer(0, 1, 16'hA880, r);
    chk({14'h0000, refi, pdif}, 16'h0003);
    rdcfg(12'h880, 1);
    host.xfer(0, 0, 16'h8000, r);
    chk(16'(pdn), 16'h0001);
    rdcfg(12'h880, 0);
    host.xfer(0, 0, 16'hF123, r);
    chk({14'h0000, samp, conv}, 16'h0000);
    rdcfg(12'h880, 0);
    for (int k = 0; k < 5; k++)
    begin
      c = cfg_tab[k];
      wr(c);
      i_adc_result <= {8'h9A, 4'(k)};
      // Counters have one writer; the scenario works from a snapshot
      samp0 = n_samp;
      conv0 = n_conv;
      host.xfer(0, 0, 16'h3000, r);
      chk({12'h000, chan}, 16'h0003);
      chk(16'(pin), 16'(!c[2]));
      host.clocks(30);
      chk(16'(n_samp - samp0), c[9] ? 16'h0018 : 16'h000C);
      chk(16'(n_conv - conv0), 16'(CONV) << c[8]);
      chk(16'(pin), 16'(c[2]));
      host.xfer(0, 0, 16'hE000, r);
      chk(r, {i_adc_result ^ (c[10] ? 12'h800 : 12'h000), 4'h0});
      chk(16'(pin), 16'h0001);
    end
    wr(12'h000);
    i_adc_result <= 12'h5C3;
    host.pin(0);
    host.wt(8);
    chk(16'(samp), 16'h0001);
    host.xfer(0, 0, 16'h5000, r);
    chk({12'h000, chan, samp}, 16'h000B);
    host.pin(1);
    host.clocks(12);
    chk({14'h0000, samp, conv}, 16'h0000);
    host.xfer(0, 0, 16'hE000, r);
    chk(r, 16'h5C30);
    // Sweep order 0-2-4-6 with threshold 3, frame sync as the only trigger
    wr(12'h04A);
    for (int k = 0; k < 3; k++)
    begin
      i_adc_result <= {8'hC0, 4'(k)};
      host.xfer(1, 0, 16'h0000, r);
      chk({12'h000, chan}, 16'(2 * k));
      host.clocks(30);
      chk(16'(pin), 16'(k < 2));
    end
    for (int k = 0; k < 3; k++)
    begin
      host.xfer(1, 0, 16'hE000, r);
      chk(r, {8'hC0, 4'(k), 4'h0});
    end
    // Repeat, then repeat sweep 0-2 alternating, threshold 1; the first result is left unread
    for (int k = 0; k < 2; k++)
    begin
      wr(k ? 12'h07B : 12'h023);
      for (int j = 0; j < 2; j++)
      begin
        i_adc_result <= {8'h3D, 2'(k), 2'(j)};
        host.xfer(0, 0, 16'h6000, r);
        if (j > 0)
          chk(r, {8'h3D, 2'(k), 2'h0, 4'h0});
        chk({12'h000, chan}, k ? 16'(2 * j) : 16'h0006);
        host.clocks(30);
        chk(16'(pin), 16'h0000);
      end
      host.xfer(0, 0, 16'hE000, r);
      chk(r, {8'h3D, 2'(k), 2'h1, 4'h0});
    end
    finish_test();
  end
endmodule
